// >>> rtl/cfr_pkg.sv
// Constants and types for the receive mailbox and filter configuration block.
package cfr_pkg;
   localparam int ADDR_W = 10;
   localparam int NBANK = 14;
   localparam int NFIFO = 2;
   localparam int DEPTH = 3;

   // Register byte addresses.
   localparam logic [ADDR_W-1:0] A_RX0_LEN = 10'h1B4;
   localparam logic [ADDR_W-1:0] A_RX0_DLO = 10'h1B8;
   localparam logic [ADDR_W-1:0] A_RX0_DHI = 10'h1BC;
   localparam logic [ADDR_W-1:0] A_RX1_LEN = 10'h1C4;
   localparam logic [ADDR_W-1:0] A_RX1_DLO = 10'h1C8;
   localparam logic [ADDR_W-1:0] A_RX1_DHI = 10'h1CC;
   localparam logic [ADDR_W-1:0] A_RX_CTRL = 10'h1D0;
   localparam logic [ADDR_W-1:0] A_FMASTER = 10'h200;
   localparam logic [ADDR_W-1:0] A_FMODE = 10'h204;
   localparam logic [ADDR_W-1:0] A_FSCALE = 10'h20C;
   localparam logic [ADDR_W-1:0] A_FFIFO = 10'h214;
   localparam logic [ADDR_W-1:0] A_FACT = 10'h21C;

   // Field layouts and reset values.
   localparam logic [31:0] FMASTER_RST = 32'h2A1C0E01;
   localparam int FILTER_INIT_MODE_BIT = 0;
   localparam logic [3:0] LEN_RSVD = 4'h0;
   localparam logic [3:0] DLC_MAX = 4'h8;
   localparam logic [3:0] BANK_LIMIT = 4'hE;
   localparam logic [15:0] TIMER_STEP = 16'h0001;
   localparam logic [1:0] CNT_ONE = 2'h1;
   localparam logic [1:0] CNT_FULL = 2'h3;
   localparam int CTRL_REL_LSB = 0;
   localparam int CTRL_OVR_LSB = 4;
   localparam logic [31:0] HRESP_OKAY = 32'h0;

   typedef logic [NBANK-1:0] cfr_bank_t;

   typedef struct packed {
      logic [15:0] stamp;
      logic [7:0] filter_match_index;
      logic [3:0] dlc;
      logic [63:0] data;
   } cfr_msg_s;

   // Accepted message from the receive and filter engine.
   typedef struct packed {
      logic valid;
      logic [3:0] bank;
      logic [7:0] filter_match_index;
      logic rtr;
      logic [3:0] dlc;
      logic [63:0] data;
   } cfr_rx_s;

   // Configuration handed to the filter engine.
   typedef struct packed {
      logic init_mode;
      cfr_bank_t list_mode;
      cfr_bank_t scale;
      cfr_bank_t fifo_select;
      cfr_bank_t active;
      cfr_bank_t write_allow;
      logic [NFIFO-1:0] pending;
   } cfr_cfg_s;

   typedef struct packed {
      logic [15:0] timer;
      logic [15:0] sof_stamp;
      logic ap_valid;
      logic ap_write;
      logic [ADDR_W-1:0] ap_addr;
      logic filter_init_mode;
      cfr_bank_t list_mode;
      cfr_bank_t scale;
      cfr_bank_t fifo_select;
      cfr_bank_t active;
      cfr_msg_s [NFIFO-1:0][DEPTH-1:0] ent;
      logic [NFIFO-1:0][1:0] cnt;
      logic [NFIFO-1:0] ovr;
      logic [31:0] rdata;
   } cfr_state_s;
endpackage

// >>> rtl/cfr_filter_regs.sv
// Receive FIFO mailboxes and acceptance filter configuration registers.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/100ps
module cfr_filter_regs (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Receive engine side.
   input wire logic sof_seen,
   input wire cfr_pkg::cfr_rx_s rx_msg,
   // Filter engine side.
   output cfr_pkg::cfr_cfg_s filt_cfg
);
   cfr_pkg::cfr_state_s s;
   cfr_pkg::cfr_state_s next_s;

   // Register map, byte addresses within the block:
   //   0x1B4, 0x1C4  length/stamp view of FIFO 0, FIFO 1 (read-only)
   //   0x1B8, 0x1C8  payload bytes 0 to 3 of FIFO 0, FIFO 1 (read-only)
   //   0x1BC, 0x1CC  payload bytes 4 to 7 of FIFO 0, FIFO 1 (read-only)
   //   0x1D0         FIFO levels, overrun flags; release and clear strobes
   //   0x200         filter master: init switch in bit 0
   //   0x204, 0x20C  bank list-mode and scale bits
   //   0x214, 0x21C  bank FIFO select and activation bits
   // Mailbox views always show entry zero, the oldest of the FIFO; an
   // empty FIFO shows whatever entry was last left in that slot.

   // The control word at 0x1D0 reads FIFO 0 level in bits 1:0, FIFO 1 level
   // in bits 3:2 and the overrun flags in bits 5:4. Writing 1 to bit 0 or 1
   // releases the oldest message of that FIFO; writing 1 to bit 4 or 5
   // clears its overrun flag, unless a message is lost in the same cycle.

   // Packs one stored message into the length/stamp view.
   function automatic logic [31:0] length_word(
      input cfr_pkg::cfr_msg_s m
   );
      logic [31:0] w;
      w = {m.stamp, m.filter_match_index, cfr_pkg::LEN_RSVD, m.dlc};
      return w;
   endfunction

   // Picks one half of the payload; byte 0 sits in the lowest lane.
   function automatic logic [31:0] data_word(
      input cfr_pkg::cfr_msg_s m,
      input logic hi
   );
      logic [31:0] w;
      if (hi) begin
         w = m.data[63:32];
      end else begin
         w = m.data[31:0];
      end
      return w;
   endfunction

   // Builds the read word for one address from a state copy.
   function automatic logic [31:0] read_word(
      input cfr_pkg::cfr_state_s st,
      input logic [cfr_pkg::ADDR_W-1:0] a
   );
      logic [31:0] w;
      w = '0;
      case (a)
         cfr_pkg::A_RX0_LEN: begin
            w = length_word(st.ent[0][0]);
         end
         cfr_pkg::A_RX1_LEN: begin
            w = length_word(st.ent[1][0]);
         end
         cfr_pkg::A_RX0_DLO: begin
            w = data_word(st.ent[0][0], 1'b0);
         end
         cfr_pkg::A_RX1_DLO: begin
            w = data_word(st.ent[1][0], 1'b0);
         end
         cfr_pkg::A_RX0_DHI: begin
            w = data_word(st.ent[0][0], 1'b1);
         end
         cfr_pkg::A_RX1_DHI: begin
            w = data_word(st.ent[1][0], 1'b1);
         end
         cfr_pkg::A_RX_CTRL: begin
            // Levels of both FIFOs, then their overrun flags.
            w[cfr_pkg::CTRL_REL_LSB +: 2] = st.cnt[0];
            w[cfr_pkg::CTRL_REL_LSB + 2 +: 2] = st.cnt[1];
            w[cfr_pkg::CTRL_OVR_LSB +: 2] = st.ovr;
         end
         cfr_pkg::A_FMASTER: begin
            // Reserved bits return their reset value whatever was written.
            w = cfr_pkg::FMASTER_RST;
            w[cfr_pkg::FILTER_INIT_MODE_BIT] = st.filter_init_mode;
         end
         cfr_pkg::A_FMODE: begin
            w[cfr_pkg::NBANK-1:0] = st.list_mode;
         end
         cfr_pkg::A_FSCALE: begin
            w[cfr_pkg::NBANK-1:0] = st.scale;
         end
         cfr_pkg::A_FFIFO: begin
            w[cfr_pkg::NBANK-1:0] = st.fifo_select;
         end
         cfr_pkg::A_FACT: begin
            w[cfr_pkg::NBANK-1:0] = st.active;
         end
         default: begin
            // Unmapped words read as zero.
            w = '0;
         end
      endcase
      return w;
   endfunction

   // Bus timing: the address phase is registered together with its read
   // data, so a read answers in its data phase with no wait state, and a
   // write lands at the edge that ends its data phase, when hwdata stands.
   // Back-to-back transfers need no idle cycle between them.
   // Only full-word transfers are expected; the transfer size is not checked.
   logic ap_take;
   logic ap_read;
   logic dp_write;
   logic [cfr_pkg::ADDR_W-1:0] ap_word;

   // Work signals of the per-FIFO update.
   logic [cfr_pkg::NFIFO-1:0] pop;
   logic [cfr_pkg::NFIFO-1:0] ovr_clr;
   logic [cfr_pkg::NFIFO-1:0] lost;
   logic [1:0] level;
   cfr_pkg::cfr_msg_s incoming;
   logic push;
   logic bank_ok;

   assign ap_take = hsel && htrans[1] && hready;
   assign ap_read = ap_take && !hwrite;
   // A data phase that carries write data for the word captured before.
   assign dp_write = s.ap_valid && s.ap_write;
   assign ap_word = haddr[cfr_pkg::ADDR_W-1:0];

   // Receive side: the engine offers at most one accepted message a cycle.
   // Its stamp is the timer value caught at the last start of frame, which
   // belongs to this message since frames never overlap on the bus.
   always_comb begin
      incoming = '0;
      incoming.stamp = s.sof_stamp;
      incoming.filter_match_index = rx_msg.filter_match_index;
      incoming.data = rx_msg.data;
      if (rx_msg.rtr) begin
         // A remote frame carries no data bytes.
         incoming.dlc = '0;
      end else if (rx_msg.dlc > cfr_pkg::DLC_MAX) begin
         // Codes above eight still mean eight bytes.
         incoming.dlc = cfr_pkg::DLC_MAX;
      end else begin
         incoming.dlc = rx_msg.dlc;
      end
      // Banks outside the implemented range never store a message.
      bank_ok = rx_msg.valid && (rx_msg.bank < cfr_pkg::BANK_LIMIT);
   end

   always_comb begin
      next_s = s;
      pop = '0;
      ovr_clr = '0;
      lost = '0;
      level = '0;
      push = 1'b0;

      // Free-running time base; it wraps at 16 bits with no flag.
      next_s.timer = s.timer + cfr_pkg::TIMER_STEP;
      if (sof_seen) begin
         // Caught at frame start so the stamp does not depend on how long
         // the frame and its filtering take.
         next_s.sof_stamp = s.timer;
      end

      // Data phase of a write taken in the previous cycle.
      if (dp_write) begin
         case (s.ap_addr)
            cfr_pkg::A_FMASTER: begin
               // Only software moves the init switch.
               next_s.filter_init_mode = hwdata[cfr_pkg::FILTER_INIT_MODE_BIT];
            end
            cfr_pkg::A_FMODE: begin
               // Configuration stays frozen while the filters run.
               if (s.filter_init_mode) begin
                  next_s.list_mode = hwdata[cfr_pkg::NBANK-1:0];
               end
            end
            cfr_pkg::A_FSCALE: begin
               // Same init-mode lock as the mode bits.
               if (s.filter_init_mode) begin
                  next_s.scale = hwdata[cfr_pkg::NBANK-1:0];
               end
            end
            cfr_pkg::A_FFIFO: begin
               // Same init-mode lock as the mode bits.
               if (s.filter_init_mode) begin
                  next_s.fifo_select = hwdata[cfr_pkg::NBANK-1:0];
               end
            end
            cfr_pkg::A_FACT: begin
               // Activation may change at any time.
               next_s.active = hwdata[cfr_pkg::NBANK-1:0];
            end
            cfr_pkg::A_RX_CTRL: begin
               // Release and overrun clear are strobes, not stored bits.
               pop = hwdata[cfr_pkg::CTRL_REL_LSB +: cfr_pkg::NFIFO];
               ovr_clr = hwdata[cfr_pkg::CTRL_OVR_LSB +: cfr_pkg::NFIFO];
            end
            cfr_pkg::A_RX0_LEN, cfr_pkg::A_RX0_DLO, cfr_pkg::A_RX0_DHI,
            cfr_pkg::A_RX1_LEN, cfr_pkg::A_RX1_DLO, cfr_pkg::A_RX1_DHI: begin
               // Mailbox views are read-only copies of stored messages.
               next_s.filter_init_mode = s.filter_init_mode;
            end
            default: begin
               // Unmapped words take no write.
               next_s.filter_init_mode = s.filter_init_mode;
            end
         endcase
      end

      // Each FIFO is a shift queue with entry zero as the oldest. Release
      // and push may fall in one cycle: the shift happens first, so the new
      // message lands behind the survivors and a non-empty FIFO keeps its level.
      for (int f = 0; f < cfr_pkg::NFIFO; f++) begin
         level = s.cnt[f];
         // Release drops the oldest entry and moves the rest up; the last
         // slot keeps a stale copy that the level marks as unused.
         if (pop[f] && level != '0) begin
            for (int k = 0; k < cfr_pkg::DEPTH - 1; k++) begin
               next_s.ent[f][k] = s.ent[f][k+1];
            end
            level = level - cfr_pkg::CNT_ONE;
         end
         push = 1'b0;
         if (bank_ok) begin
            // The bank's assignment bit picks the FIFO.
            push = s.fifo_select[rx_msg.bank] == f[0];
         end
         if (push) begin
            if (level == cfr_pkg::CNT_FULL) begin
               // A full FIFO keeps its three oldest messages.
               lost[f] = 1'b1;
            end else begin
               // Entry zero is the oldest, so a push into an empty FIFO
               // changes every mailbox field in the same cycle.
               next_s.ent[f][level] = incoming;
               level = level + cfr_pkg::CNT_ONE;
            end
         end
         next_s.cnt[f] = level;
         // A loss in the clearing cycle keeps the flag set.
         if (lost[f]) begin
            next_s.ovr[f] = 1'b1;
         end else if (ovr_clr[f]) begin
            next_s.ovr[f] = 1'b0;
         end
      end

      // Address phase: capture the request and build read data from the
      // updated state, so a read right after a write sees the new value.
      if (ap_take) begin
         next_s.ap_valid = 1'b1;
         next_s.ap_write = hwrite;
         next_s.ap_addr = ap_word;
      end else begin
         next_s.ap_valid = 1'b0;
      end
      if (ap_read) begin
         next_s.rdata = read_word(next_s, ap_word);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s.timer <= '0;
         s.sof_stamp <= '0;
         s.ap_valid <= 1'b0;
         s.ap_write <= 1'b0;
         s.ap_addr <= '0;
         // The filters leave reset in init mode, as the master reads back.
         s.filter_init_mode <= cfr_pkg::FMASTER_RST[cfr_pkg::FILTER_INIT_MODE_BIT];
         s.list_mode <= '0;
         s.scale <= '0;
         s.fifo_select <= '0;
         s.active <= '0;
         // Mailbox contents are cleared so the views never read unknown.
         s.ent <= '0;
         s.cnt <= '0;
         s.ovr <= '0;
         s.rdata <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Zero wait states: every transfer completes in one data phase.
   assign hreadyout = 1'b1;
   assign hresp = cfr_pkg::HRESP_OKAY[0];
   assign hrdata = s.rdata;

   // Configuration to the filter engine, straight from the registers.
   always_comb begin
      filt_cfg.init_mode = s.filter_init_mode;
      filt_cfg.list_mode = s.list_mode;
      filt_cfg.scale = s.scale;
      filt_cfg.fifo_select = s.fifo_select;
      filt_cfg.active = s.active;
      // Bank contents are writable while inactive or in init mode.
      filt_cfg.write_allow = ~s.active | {cfr_pkg::NBANK{s.filter_init_mode}};
      // Pending tells the engine which FIFOs hold a message.
      for (int f = 0; f < cfr_pkg::NFIFO; f++) begin
         filt_cfg.pending[f] = (s.cnt[f] != '0);
      end
   end
endmodule

// >>> dv/cfr_filter_regs_chk.sv
// Bound checker for the receive mailbox and filter register block.
`timescale 1ns/100ps
module cfr_filter_regs_chk (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Bus.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   // Engine sides.
   input wire cfr_pkg::cfr_rx_s rx_msg,
   input wire cfr_pkg::cfr_cfg_s filt_cfg
);
   // Data phase kind and address: write, read, address.
   logic [11:0] dp;
   wire [9:0] da = dp[9:0];
   wire wfm = dp[11] && da == cfr_pkg::A_FMASTER;
   wire wmd = dp[11] && da == cfr_pkg::A_FMODE;
   wire wff = dp[11] && da == cfr_pkg::A_FFIFO;
   wire rfm = dp[10] && da == cfr_pkg::A_FMASTER;
   wire rmd = dp[10] && da == cfr_pkg::A_FMODE;
   wire rln = dp[10] && da == cfr_pkg::A_RX0_LEN;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp <= '0;
      end else if (hready) begin
         dp <= {hsel & htrans[1] & hwrite, hsel & htrans[1] & ~hwrite,
            haddr[9:0]};
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_init_wr; wfm |=> filt_cfg.init_mode == $past(hwdata[0]);
   endproperty
   a_init_wr: assert property (p_init_wr) else $error("init bit");
   property p_init_own; $changed(filt_cfg.init_mode) |-> $past(wfm);
   endproperty
   a_init_own: assert property (p_init_own) else $error("init self");
   property p_fm_rsvd; rfm |-> hrdata[31:1] == cfr_pkg::FMASTER_RST[31:1];
   endproperty
   a_fm_rsvd: assert property (p_fm_rsvd) else $error("master rsvd");
   property p_mode_wr; wmd && filt_cfg.init_mode
      |=> filt_cfg.list_mode == $past(hwdata[13:0]); endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode write");
   property p_fifo_lock; $changed(filt_cfg.fifo_select)
      |-> $past(wff && filt_cfg.init_mode); endproperty
   a_fifo_lock: assert property (p_fifo_lock) else $error("fifo sel");
   property p_mode_rsvd; rmd |-> hrdata[31:14] == 18'h0; endproperty
   a_mode_rsvd: assert property (p_mode_rsvd) else $error("mode rsvd");
   property p_len_rsvd; rln |-> hrdata[7:4] == cfr_pkg::LEN_RSVD; endproperty
   a_len_rsvd: assert property (p_len_rsvd) else $error("len rsvd");
   property p_pend; $rose(filt_cfg.pending[0]) |-> $past(rx_msg.valid);
   endproperty
   a_pend: assert property (p_pend) else $error("pending");
endmodule
bind cfr_filter_regs cfr_filter_regs_chk cfr_filter_regs_chk_inst (.hclk,
   .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
   .rx_msg, .filt_cfg);

// >>> dv/cfr_rx_node.sv
// Behavioural remote node that delivers accepted frames to the block.
`timescale 1ns/100ps
module cfr_rx_node (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // Bench command.
   input wire cfr_pkg::cfr_rx_s cmd,
   input wire logic [3:0] gap,
   // Receive side.
   output logic sof_seen,
   output cfr_pkg::cfr_rx_s rx_msg,
   output logic [15:0] sof_cyc,
   output logic busy
);
   logic [15:0] cyc;
   logic [3:0] left;
   // Idle fields flip every cycle so a stale sample never looks right.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {cyc, left, busy, sof_seen, sof_cyc} <= '0;
         rx_msg <= '0;
      end else begin
         cyc <= cyc + 16'h1;
         sof_seen <= 1'b0;
         rx_msg <= ~rx_msg;
         rx_msg.valid <= 1'b0;
         if (cmd.valid && !busy) begin
            sof_seen <= 1'b1;
            sof_cyc <= cyc;
            left <= gap;
            busy <= 1'b1;
         end else if (busy && left != 4'h0) begin
            left <= left - 4'h1;
         end else if (busy) begin
            rx_msg <= cmd;
            rx_msg.valid <= 1'b1;
            busy <= 1'b0;
         end
      end
   end
endmodule

// >>> dv/tb.sv
// Self-checking bench for the receive mailbox and filter register block.
`timescale 1ns/100ps
module tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout;
   logic [31:0] hrdata;
   logic sof_seen;
   logic busy;
   logic [15:0] sof_cyc;
   cfr_pkg::cfr_rx_s rx_msg;
   cfr_pkg::cfr_rx_s cmd = '0;
   logic [3:0] gap = 4'h0;
   logic [31:0] rd;
   logic [15:0] st0;
   logic [15:0] sc0;
   logic [15:0] sc1;
   logic [9:0] fa [3] = '{cfr_pkg::A_FMODE, cfr_pkg::A_FSCALE,
      cfr_pkg::A_FFIFO};
   int mismatches = 0;
   int compares = 0;
   always #5 hclk = ~hclk;
   cfr_filter_regs cfr_filter_regs_inst (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
      .hreadyout, .hresp(), .hrdata, .sof_seen, .rx_msg, .filt_cfg());
   cfr_rx_node cfr_rx_node_inst (.hclk, .hresetn, .cmd, .gap, .sof_seen,
      .rx_msg, .sof_cyc, .busy);
   task automatic bus(input logic w, input logic [9:0] a,
      input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [9:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic send(input logic [3:0] b, input logic [7:0] f,
      input logic r, input logic [3:0] n, input logic [63:0] d);
      cmd <= '{1'b1, b, f, r, n, d};
      @(posedge hclk);
      cmd.valid <= 1'b0;
      do @(posedge hclk); while (busy);
      @(posedge hclk);
      gap <= gap + 4'h2;
   endtask
   task automatic t_cfg;
      rchk(cfr_pkg::A_FMASTER, 32'h2A1C0E01);
      foreach (fa[i]) rchk(fa[i], 32'h0);
      bus(1'b1, cfr_pkg::A_FMASTER, 32'h0);
      bus(1'b1, cfr_pkg::A_FMODE, 32'hFFFFFFFF);
      rchk(cfr_pkg::A_FMODE, 32'h0);
      bus(1'b1, cfr_pkg::A_FMASTER, 32'hFFFFFFFF);
      foreach (fa[i]) begin
         bus(1'b1, fa[i], 32'hFFFFFFFF);
         rchk(fa[i], 32'h00003FFF);
      end
      bus(1'b1, cfr_pkg::A_FFIFO, 32'h00000002);
      bus(1'b1, cfr_pkg::A_FMASTER, 32'h0);
      rchk(cfr_pkg::A_FMASTER, 32'h2A1C0E00);
      bus(1'b1, cfr_pkg::A_FSCALE, 32'h0);
      rchk(cfr_pkg::A_FSCALE, 32'h00003FFF);
      $display("test config done");
   endtask
   task automatic t_rx;
      send(4'h0, 8'h05, 1'b0, 4'h8, 64'h8877665544332211);
      sc0 = sof_cyc;
      send(4'h1, 8'h1A, 1'b1, 4'h5, 64'h0123456789ABCDEF);
      sc1 = sof_cyc;
      send(4'h0, 8'h06, 1'b0, 4'hF, 64'hFFEEDDCCBBAA9988);
      send(4'h0, 8'h07, 1'b0, 4'h3, 64'h0);
      send(4'h0, 8'h08, 1'b0, 4'h2, 64'h0);
      rchk(cfr_pkg::A_RX_CTRL, 32'h00000017);
      bus(1'b0, cfr_pkg::A_RX0_LEN, 32'h0);
      st0 = rd[31:16];
      chk({16'h0, rd[15:0]}, 32'h00000508);
      rchk(cfr_pkg::A_RX0_DLO, 32'h44332211);
      rchk(cfr_pkg::A_RX0_DHI, 32'h88776655);
      bus(1'b1, cfr_pkg::A_RX0_DLO, 32'h0);
      rchk(cfr_pkg::A_RX0_DLO, 32'h44332211);
      bus(1'b0, cfr_pkg::A_RX1_LEN, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h00001A00);
      chk({16'h0, rd[31:16] - st0}, {16'h0, sc1 - sc0});
      bus(1'b1, cfr_pkg::A_RX_CTRL, 32'h00000001);
      bus(1'b0, cfr_pkg::A_RX0_LEN, 32'h0);
      chk({16'h0, rd[15:0]}, 32'h00000608);
      rchk(cfr_pkg::A_RX0_DHI, 32'hFFEEDDCC);
      $display("test receive done");
   endtask
   task automatic close_out;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_cfg;
      t_rx;
      close_out;
   end
   initial begin
      repeat (5000) @(posedge hclk);
      mismatches++;
      close_out;
   end
endmodule
